/* design/vvc_crop_top.sv */
`timescale 1ns/1ps
module vvc_crop_top #(
	parameter int FIFO_DEPTH = vvc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [vvc_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [vvc_pkg::DATA_W-1:0] pwdata_in,
	output logic [vvc_pkg::DATA_W-1:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Video from source
	input wire logic vid_valid_in,
	input wire vvc_pkg::vvc_word_t vid_word_in,
	output logic vid_ready_out,
	// Video toward serial ports, one beat for both ports
	output logic out_valid_out,
	output vvc_pkg::vvc_word_t [vvc_pkg::NUM_PORTS-1:0] out_word_out,
	input wire logic out_ready_in
);

	localparam int NP = vvc_pkg::NUM_PORTS;
	localparam int LW = vvc_pkg::LINE_W;
	localparam int LO = vvc_pkg::LO_W;
	localparam int HI = vvc_pkg::HI_W;
	localparam int DW = vvc_pkg::DATA_W;
	localparam int CW = $clog2(FIFO_DEPTH+1);

	// ------------------------------------------------------------
	// Input buffer
	// ------------------------------------------------------------
	logic fifo_valid;
	vvc_pkg::vvc_word_t fifo_word;
	logic fifo_ready;
	logic [CW-1:0] fifo_level;

	vvc_fifo #(
		.W(vvc_pkg::WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(core_clk_in),
		.arst_n_in(arst_n_in),
		.wr_valid_in(vid_valid_in),
		.wr_data_in(vid_word_in),
		.wr_ready_out(vid_ready_out),
		.rd_valid_out(fifo_valid),
		.rd_data_out(fifo_word),
		.rd_ready_in(fifo_ready),
		.level_out(fifo_level)
	);

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	logic pready_r;
	logic pslverr_r;
	logic [DW-1:0] prdata_r;
	logic sel_r;

	wire access = psel_in && penable_in;
	wire first_beat = access && !pready_r;
	wire apb_wr = access && pready_r && pwrite_in && !pslverr_r;

	wire hit_ctrl = (paddr_in == vvc_pkg::ADDR_CROP_CTRL);
	wire hit_flo = (paddr_in == vvc_pkg::ADDR_FIRST_LO);
	wire hit_fhi = (paddr_in == vvc_pkg::ADDR_FIRST_HI);
	wire hit_llo = (paddr_in == vvc_pkg::ADDR_LAST_LO);
	wire hit_lhi = (paddr_in == vvc_pkg::ADDR_LAST_HI);
	wire hit_sel = (paddr_in == vvc_pkg::ADDR_PORT_SEL);
	wire hit_stat = (paddr_in == vvc_pkg::ADDR_STATUS);
	wire hit_any = hit_ctrl || hit_flo || hit_fhi || hit_llo || hit_lhi
		|| hit_sel || hit_stat;
	// Status is read-only; a write to it is flagged as an error
	wire bad = !hit_any || (hit_stat && pwrite_in);

	// ------------------------------------------------------------
	// Per-port crop state
	// ------------------------------------------------------------
	logic [NP-1:0] en_r;
	logic [LW-1:0] first_r [NP];
	logic [LW-1:0] last_r [NP];
	logic [LW-1:0] line_r [NP];
	logic [NP-1:0] win_r;
	logic out_valid_r;
	vvc_pkg::vvc_word_t [NP-1:0] out_word_r;

	// Both ports move in lock step, so one stall holds both
	wire fire = fifo_valid && (!out_valid_r || out_ready_in);
	assign fifo_ready = !out_valid_r || out_ready_in;

	genvar p;
	generate
		for (p = 0; p < NP; p++) begin : g_port
			wire wsel = apb_wr && (sel_r == 1'(p));
			wire [LW-1:0] cur_line;
			wire in_win;

			// Line index of the word now leaving the buffer
			assign cur_line = fifo_word.sof ? '0 :
				(fifo_word.sol ? LW'(line_r[p] + 1'b1) : line_r[p]);
			assign in_win = (cur_line >= first_r[p])
				&& (cur_line <= last_r[p]);

			always_ff @(posedge core_clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					en_r[p] <= vvc_pkg::RST_CROP_EN;
					first_r[p] <= vvc_pkg::RST_LINE;
					last_r[p] <= vvc_pkg::RST_LINE;
				end else if (wsel) begin
					if (hit_ctrl) begin
						en_r[p] <= pwdata_in[vvc_pkg::CROP_EN_BIT];
					end
					if (hit_flo) begin
						first_r[p][LO-1:0] <= pwdata_in[LO-1:0];
					end
					if (hit_fhi) begin
						first_r[p][LW-1:LO] <= pwdata_in[HI-1:0];
					end
					if (hit_llo) begin
						last_r[p][LO-1:0] <= pwdata_in[LO-1:0];
					end
					if (hit_lhi) begin
						last_r[p][LW-1:LO] <= pwdata_in[HI-1:0];
					end
				end
			end

			always_ff @(posedge core_clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					line_r[p] <= vvc_pkg::RST_LINE;
					win_r[p] <= 1'b0;
					out_word_r[p] <= '0;
				end else if (fire) begin
					line_r[p] <= cur_line;
					win_r[p] <= in_win;
					out_word_r[p] <= fifo_word;
					// Outside the window the pixel stays, only the flag drops
					out_word_r[p].active_video_flag <= fifo_word.active_video_flag
						&& (!en_r[p] || in_win);
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			out_valid_r <= 1'b0;
		end else if (fire) begin
			out_valid_r <= 1'b1;
		end else if (out_ready_in) begin
			out_valid_r <= 1'b0;
		end
	end

	assign out_valid_out = out_valid_r;
	assign out_word_out = out_word_r;

	// ------------------------------------------------------------
	// Register read mux, selected port only
	// ------------------------------------------------------------
	wire [LW-1:0] sel_first = first_r[sel_r];
	wire [LW-1:0] sel_last = last_r[sel_r];
	wire [LW-1:0] sel_line = line_r[sel_r];
	wire [DW-1:0] rd_ctrl = DW'({en_r[sel_r], 7'h00});
	wire [DW-1:0] rd_flo = DW'(sel_first[LO-1:0]);
	wire [DW-1:0] rd_fhi = DW'(sel_first[LW-1:LO]);
	wire [DW-1:0] rd_llo = DW'(sel_last[LO-1:0]);
	wire [DW-1:0] rd_lhi = DW'(sel_last[LW-1:LO]);
	wire [DW-1:0] rd_sel = DW'(sel_r);
	wire [DW-1:0] rd_stat = (DW'(fifo_level) << vvc_pkg::STAT_LEVEL_LSB)
		| (DW'(win_r[sel_r]) << vvc_pkg::STAT_WIN_BIT)
		| DW'(sel_line);
	wire [DW-1:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_flo ? rd_flo :
		hit_fhi ? rd_fhi :
		hit_llo ? rd_llo :
		hit_lhi ? rd_lhi :
		hit_sel ? rd_sel :
		hit_stat ? rd_stat : '0;

	// ------------------------------------------------------------
	// APB answer: one wait state, then ready with data
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else if (first_beat) begin
			pready_r <= 1'b1;
			pslverr_r <= bad;
			prdata_r <= (pwrite_in || bad) ? '0 : rd_mux;
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sel_r <= vvc_pkg::RST_PORT_SEL;
		end else if (apb_wr && hit_sel) begin
			sel_r <= pwdata_in[0];
		end
	end

	assign prdata_out = prdata_r;
	assign pready_out = pready_r;
	assign pslverr_out = pslverr_r;

endmodule

/* design/vvc_pkg.sv */
package vvc_pkg;

	// ------------------------------------------------------------
	// Widths and sizes
	// ------------------------------------------------------------
	localparam int PIX_W = 24;
	localparam int LINE_W = 13;
	localparam int LO_W = 8;
	localparam int HI_W = LINE_W - LO_W;
	localparam int NUM_PORTS = 2;
	localparam int FIFO_DEPTH = 16;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_CROP_CTRL = 8'h37;
	localparam logic [7:0] IDX_FIRST_LO = 8'h3A;
	localparam logic [7:0] IDX_FIRST_HI = 8'h3B;
	localparam logic [7:0] IDX_LAST_LO = 8'h3C;
	localparam logic [7:0] IDX_LAST_HI = 8'h3D;
	localparam logic [7:0] IDX_PORT_SEL = 8'h41;
	localparam logic [7:0] IDX_STATUS = 8'h42;

	localparam logic [ADDR_W-1:0] ADDR_CROP_CTRL = {2'b00, IDX_CROP_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_FIRST_LO = {2'b00, IDX_FIRST_LO, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_FIRST_HI = {2'b00, IDX_FIRST_HI, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_LAST_LO = {2'b00, IDX_LAST_LO, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_LAST_HI = {2'b00, IDX_LAST_HI, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PORT_SEL = {2'b00, IDX_PORT_SEL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CROP_EN_BIT = 7;
	localparam int STAT_WIN_BIT = 16;
	localparam int STAT_LEVEL_LSB = 20;
	localparam logic RST_CROP_EN = 1'b0;
	localparam logic [LINE_W-1:0] RST_LINE = 13'h0000;
	localparam logic RST_PORT_SEL = 1'b0;

	// ------------------------------------------------------------
	// Video word: frame start, line start, data enable, pixel
	// ------------------------------------------------------------
	typedef struct packed {
		logic sof;
		logic sol;
		logic active_video_flag;
		logic [PIX_W-1:0] pix;
	} vvc_word_t;

	localparam int WORD_W = $bits(vvc_word_t);

endpackage

/* design/vvc_fifo.sv */
`timescale 1ns/1ps
module vvc_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Fill side
	input wire logic wr_valid_in,
	input wire logic [W-1:0] wr_data_in,
	output logic wr_ready_out,
	// Drain side
	output logic rd_valid_out,
	output logic [W-1:0] rd_data_out,
	input wire logic rd_ready_in,
	// Status
	output logic [$clog2(DEPTH+1)-1:0] level_out
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wptr_r;
	logic [AW-1:0] rptr_r;
	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;
	logic ready_r;
	logic valid_r;
	logic [W-1:0] data_r;

	wire push = wr_valid_in && ready_r;
	wire load = (count_r != '0) && (!valid_r || rd_ready_in);

	assign count_nxt = count_r + CW'(push) - CW'(load);
	assign wr_ready_out = ready_r;
	assign rd_valid_out = valid_r;
	assign rd_data_out = data_r;
	assign level_out = count_r;

	// Storage has no reset; pointers, count, flags and output data do
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_r[wptr_r] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wptr_r <= '0;
			rptr_r <= '0;
			count_r <= '0;
			ready_r <= 1'b0;
			valid_r <= 1'b0;
			data_r <= '0;
		end else begin
			wptr_r <= push ? AW'((wptr_r + 1'b1) % DEPTH) : wptr_r;
			rptr_r <= load ? AW'((rptr_r + 1'b1) % DEPTH) : rptr_r;
			count_r <= count_nxt;
			ready_r <= (count_nxt != CW'(DEPTH));
			if (load) begin
				data_r <= mem_r[rptr_r];
				valid_r <= 1'b1;
			end else if (rd_ready_in) begin
				valid_r <= 1'b0;
			end
		end
	end

endmodule

/* verif/vvc_crop_properties.sv */
`timescale 1ns/1ps
module vvc_crop_properties #(
	parameter int FIFO_DEPTH = vvc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	// APB
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [vvc_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [vvc_pkg::DATA_W-1:0] pwdata_in,
	input wire logic [vvc_pkg::DATA_W-1:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	// Video
	input wire logic vid_valid_in,
	input wire vvc_pkg::vvc_word_t vid_word_in,
	input wire logic vid_ready_out,
	input wire logic out_valid_out,
	input wire vvc_pkg::vvc_word_t [vvc_pkg::NUM_PORTS-1:0] out_word_out,
	input wire logic out_ready_in
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	ready_pulse_a: assert property (pready_out |=> !pready_out)
		else $error("pready longer than one cycle");
	ready_cause_a: assert property (
		pready_out |-> $past(psel_in && penable_in && !pready_out))
		else $error("pready without access phase");
	one_wait_a: assert property (
		psel_in && penable_in && !pready_out |=> pready_out)
		else $error("pready not after one wait");
	err_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("pslverr without pready");
	err_zero_a: assert property (pslverr_out |-> prdata_out == 0)
		else $error("read data not zero on error");
	write_zero_a: assert property (pready_out && pwrite_in |-> prdata_out == 0)
		else $error("read data not zero on write");
	out_hold_a: assert property (
		out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_word_out))
		else $error("output beat changed while stalled");
	ports_same_a: assert property (out_valid_out |->
		out_word_out[0].pix == out_word_out[1].pix &&
		out_word_out[0].sof == out_word_out[1].sof &&
		out_word_out[0].sol == out_word_out[1].sol)
		else $error("port copies differ");
	cover property (pready_out && pwrite_in);
	cover property (pslverr_out);
	cover property (out_valid_out && !out_ready_in);
	cover property (!vid_ready_out && vid_valid_in);
endmodule

bind vvc_crop_top vvc_crop_properties #(.FIFO_DEPTH(FIFO_DEPTH)) i_props (.*);

/* verif/vvc_sink_model.sv */
`timescale 1ns/1ps
module vvc_sink_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Control and handshake
	input wire logic stall_in,
	output logic ready_out
);
	int seed = 19;
	// Random gaps, like a link that is busy with control slots
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ready_out <= 1'b0;
		end else begin
			ready_out <= !stall_in && ($random(seed) % 4 != 0);
		end
	end
endmodule

/* verif/test_video_vertical_crop_window.sv */
`timescale 1ns/1ps
module test_video_vertical_crop_window;
	localparam int NL = 8;
	localparam int LW = 3;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, vval = 0, stall = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, d;
	logic pready, pslverr, vrdy, oval, ordy, e;
	vvc_pkg::vvc_word_t vword = '0;
	vvc_pkg::vvc_word_t [1:0] oword, exp_w;
	vvc_pkg::vvc_word_t [1:0] exp_q[$];
	int seed = 19, n_errors = 0, n_compared = 0, i, k, p;
	logic en_c[2];
	logic [12:0] f_c[2], l_c[2];
	logic [11:0] ra[5] = '{vvc_pkg::ADDR_CROP_CTRL, vvc_pkg::ADDR_FIRST_LO,
		vvc_pkg::ADDR_FIRST_HI, vvc_pkg::ADDR_LAST_LO, vvc_pkg::ADDR_LAST_HI};
	logic [31:0] mk[5] = '{32'h0000_0080, 32'h0000_00FF, 32'h0000_001F,
		32'h0000_00FF, 32'h0000_001F};
	always #10 clk = ~clk;
	vvc_crop_top i_dut (.core_clk_in(clk), .arst_n_in(rst_n), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.vid_valid_in(vval), .vid_word_in(vword), .vid_ready_out(vrdy),
		.out_valid_out(oval), .out_word_out(oword), .out_ready_in(ordy));
	vvc_sink_model i_sink (.clk_in(clk), .arst_n_in(rst_n), .stall_in(stall),
		.ready_out(ordy));
	// ------------------------------------------------------------
	// Checks and bus tasks
	// ------------------------------------------------------------
	task chk(input string s, input logic [63:0] x, input logic [63:0] y);
		n_compared++;
		if (x !== y) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", s, x, y);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] dw);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1; pwr <= w; paddr <= a; pwdata <= dw; pen <= 0;
		@(posedge clk) pen <= 1;
		// No limit here: the watchdog ends a hung transfer
		do begin @(posedge clk); n++; end while (pready !== 1'b1);
		q = prdata; e = pslverr;
		psel <= 0; pen <= 0;
		chk("apb_wait", 2, n);
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
		apb(0, a, 0);
		chk("rdata", x, q);
		chk("rerr", xe, e);
	endtask
	task cfg(input int pp, input logic en, input logic [12:0] f, input logic [12:0] l);
		apb(1, vvc_pkg::ADDR_PORT_SEL, pp);
		apb(1, vvc_pkg::ADDR_CROP_CTRL, {en, 7'h00});
		apb(1, vvc_pkg::ADDR_FIRST_LO, f[7:0]);
		apb(1, vvc_pkg::ADDR_FIRST_HI, f[12:8]);
		apb(1, vvc_pkg::ADDR_LAST_LO, l[7:0]);
		apb(1, vvc_pkg::ADDR_LAST_HI, l[12:8]);
		en_c[pp] = en; f_c[pp] = f; l_c[pp] = l;
	endtask
	function logic keep(input int pp, input int ln);
		return !en_c[pp] || (f_c[pp] <= ln && ln <= l_c[pp]);
	endfunction
	// Valid stays up across words; the frame task drops it at the end
	task frame(input int nl);
		int n, ln, w;
		for (ln = 0; ln < nl; ln++) for (w = 0; w < LW; w++) begin
			vword.sof <= (ln == 0 && w == 0); vword.sol <= (ln != 0 && w == 0);
			d = $random(seed);
			vword.active_video_flag <= d[31]; vword.pix <= d[23:0];
			for (p = 0; p < 2; p++) begin
				exp_w[p] = {ln == 0 && w == 0, ln != 0 && w == 0, d[31] & keep(p, ln), d[23:0]};
			end
			exp_q.push_back(exp_w);
			vval <= 1; n = 0;
			do begin @(posedge clk); n++; end while (vrdy !== 1'b1 && n < 100);
			chk("vid_wait", 0, n >= 100);
		end
		vval <= 0;
	endtask
	task drain;
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 2000) begin @(posedge clk); n++; end
		chk("drain", 0, n >= 2000);
	endtask
	always @(posedge clk) if (oval === 1'b1 && ordy === 1'b1) begin
		if (exp_q.size() == 0) chk("extra_beat", 0, 1);
		else chk("out_word", exp_q.pop_front(), oword);
	end
	task stop_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		for (i = 0; i < 5; i++) rchk(ra[i], 0, 0);
		for (i = 0; i < 5; i++) begin
			d = $random(seed);
			apb(1, ra[i], d);
			rchk(ra[i], d & mk[i], 0);
		end
		apb(1, vvc_pkg::ADDR_PORT_SEL, 1);
		rchk(vvc_pkg::ADDR_PORT_SEL, 1, 0);
		for (i = 0; i < 5; i++) rchk(ra[i], 0, 0);
		rchk(12'h0FC, 0, 1);
		apb(1, vvc_pkg::ADDR_STATUS, 1);
		chk("status_err", 1, e);
		cfg(0, 1, 0, NL - 1);
		cfg(1, 1, 3, 2);
		frame(NL);
		drain;
		for (k = 0; k < 4; k++) begin
			for (i = 0; i < 2; i++) cfg(i, $random(seed), {$random(seed)} % NL, {$random(seed)} % NL);
			frame(NL);
			drain;
		end
		stall <= 1;
		frame(6);
		@(posedge clk);
		#1 chk("full", 0, vrdy);
		// Stalled: buffer full, only line 0 has left for port 1
		rchk(vvc_pkg::ADDR_STATUS, (32'(vvc_pkg::FIFO_DEPTH) << vvc_pkg::STAT_LEVEL_LSB)
			| (32'(f_c[1] == 0) << vvc_pkg::STAT_WIN_BIT), 0);
		stall <= 0;
		drain;
		stop_test;
	end
	initial begin
		#400000;
		n_errors++;
		stop_test;
	end
endmodule
